// ### logic/hsc_device.sv
// device end: register file, dual-spin sampler and link answerer
`timescale 1ns/1ns
`default_nettype none
`include "hsc_map.svh"
// How it works
// RULE1: scale code register resets to 9, unity
// RULE2: scale code maps to tabulated percentage factor
// RULE3: host keeps analog front test bits fixed
// RULE4: host sets polarity bit after every power-up
// RULE5: all five element results readable after interrupt
// RULE6: two signed 12-bit spins, split high/low
// RULE7: each cycle samples forward then reverse spin
// RULE8: host rebuilds values, halves forward minus reverse
// RULE9: six-bit gain, top bits zero, reset 20h
// RULE10: host calibrates gain toward 2867, else 3Fh
// RULE11: reset clears registers, then stays off; here one conversion runs when the init delay ends
// RULE12: host pulses reset pin low over 100 ns
// RULE13: after wait, poll 0Fh for F0h/F1h
// RULE14: host may write 86h to invert polarity
// RULE15: host configures 2Bh, 2Ch, 2Dh, then 0Fh
// RULE16: host toggles polarity if centre reads negative
// RULE17: 0Fh bit 7 idle, bits 6:4 timebase
// RULE18: data-ready interrupt on each new result
// RULE19: all registers reached over the link
// RULE20: gain top bits ignore writes, read zero
module hsc_device #(
  parameter int INIT_CYC = `HSC_INIT_CYC,
  parameter int TB_UNIT = `HSC_TB_UNIT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  hsc_link_if.dev link,
  output logic adc_req,
  output logic [2:0] adc_elem,
  output logic adc_rev,
  input wire logic adc_valid,
  input wire hsc_pkg::hsc_sample_t adc_data,
  output logic [5:0] gain_code,
  output logic [15:0] scale_x10,
  output logic polarity_inv,
  output logic idle_mode
);
  import hsc_pkg::*;

  // ----------------------------------------
  // scale factor table, tenths of a percent
  // ----------------------------------------
  function automatic logic [15:0] scale_factor(input hsc_byte_t code);
    logic [15:0] f;
    f = 16'h0000;
    case (code)
      8'd31: f = 16'd313;
      8'd30: f = 16'd322;
      8'd29: f = 16'd334;
      8'd28: f = 16'd346;
      8'd27: f = 16'd357;
      8'd26: f = 16'd371;
      8'd25: f = 16'd385;
      8'd24: f = 16'd400;
      8'd23: f = 16'd416;
      8'd22: f = 16'd436;
      8'd21: f = 16'd455;
      8'd20: f = 16'd477;
      8'd19: f = 16'd500;
      8'd18: f = 16'd525;
      8'd17: f = 16'd555;
      8'd16: f = 16'd588;
      8'd15: f = 16'd625;
      8'd14: f = 16'd666;
      8'd13: f = 16'd715;
      8'd12: f = 16'd770;
      8'd11: f = 16'd834;
      8'd10: f = 16'd908;
      8'd9: f = 16'd1000;
      8'd8: f = 16'd1111;
      8'd47: f = 16'd1176;
      8'd7: f = 16'd1250;
      8'd45: f = 16'd1334;
      8'd6: f = 16'd1428;
      8'd43: f = 16'd1539;
      8'd5: f = 16'd1666;
      8'd41: f = 16'd1818;
      8'd4: f = 16'd2000;
      8'd79: f = 16'd2105;
      8'd39: f = 16'd2223;
      8'd77: f = 16'd2354;
      8'd3: f = 16'd2500;
      8'd75: f = 16'd2666;
      8'd37: f = 16'd2857;
      8'd73: f = 16'd3076;
      8'd2: f = 16'd3334;
      8'd71: f = 16'd3637;
      8'd35: f = 16'd4000;
      8'd69: f = 16'd4445;
      8'd1: f = 16'd5000;
      8'd67: f = 16'd5715;
      default: f = 16'h0000;
    endcase
    return f;
  endfunction

  // ----------------------------------------
  // link input synchronisers
  // ----------------------------------------
  logic [19:0] sync1_reg, sync2_reg;
  logic lclk_d_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 20'hFFFFF;
      sync2_reg <= 20'hFFFFF;
      lclk_d_reg <= 1'b1;
    end else if (ce) begin
      sync1_reg <= {link.reset_pin_low, link.link_clk, link.req, link.we, link.addr, link.wdata};
      sync2_reg <= sync1_reg;
      lclk_d_reg <= sync2_reg[18];
    end
  end
  wire pin_rst_s = !sync2_reg[19];
  wire lclk_rise = sync2_reg[18] && !lclk_d_reg;
  wire req_s = sync2_reg[17];
  wire we_s = sync2_reg[16];
  wire [7:0] addr_s = sync2_reg[15:8];
  wire [7:0] wd_s = sync2_reg[7:0];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic soft_reg, ack_reg, busy_reg, idle_reg, intdis_reg, intfn_reg, dv_reg, int_low_reg;
  logic pend_reg, adc_req_reg, rev_reg;
  logic [2:0] tb_reg, elem_reg;
  logic [5:0] gain_reg;
  logic [7:0] scale_reg, afc_reg, mid_reg, outer_reg, rdata_reg;
  logic [15:0] factor_reg;
  logic [31:0] init_cnt, tb_cnt;
  hsc_sample_t work_reg [10];
  hsc_sample_t res_reg [10];
  hsc_conv_e cst_reg;
  hsc_byte_t rd_mux;

  // pin and soft reset both clear state; no supply monitor re-arms it (see RULE11)
  wire dev_rst = !rst_n || pin_rst_s || soft_reg;
  wire acc = lclk_rise && req_s && !ack_reg; // see RULE19
  wire wr = acc && we_s && !busy_reg;
  wire y_read = acc && !we_s && (addr_s == `HSC_OFF_Y);
  // widen before adding so timebase 7 gives eight units, not zero
  wire [31:0] tb_period = 32'(TB_UNIT) * ({29'h0, tb_reg} + 32'h1);
  wire tick = !idle_reg && (tb_cnt == tb_period - 32'h1); // see RULE17
  wire start_ev = (busy_reg && init_cnt == 32'(INIT_CYC - 1)) || tick ||
    (y_read && idle_reg); // see RULE7

  // raw result bytes: groups run element 3,2,1,0 then centre, each neg hi/lo, pos hi/lo
  wire [4:0] raw_idx = 5'(addr_s - `HSC_OFF_RAW_LO);
  wire raw_in = addr_s >= `HSC_OFF_RAW_LO && addr_s <= `HSC_OFF_RAW_HI;
  wire [2:0] raw_elem = (raw_idx[4:2] == 3'h4) ? 3'h4 : 3'(3'h3 - raw_idx[4:2]);
  wire [3:0] raw_sel = {raw_elem, ~raw_idx[1]};
  wire [11:0] raw_val = res_reg[raw_sel];
  wire [7:0] raw_byte = raw_idx[0] ? raw_val[7:0] :
    {{4{raw_val[11]}}, raw_val[11:8]}; // see RULE6

  always_comb begin
    rd_mux = 8'h00;
    if (addr_s == `HSC_OFF_CTRL1) begin
      // reads zero until the reset sequence completes (see RULE13)
      rd_mux = busy_reg ? 8'h00 : {idle_reg, tb_reg, intdis_reg, intfn_reg, 1'b0, dv_reg};
    end else if (raw_in) begin
      rd_mux = raw_byte; // see RULE5
    end else if (addr_s == `HSC_OFF_GAIN) begin
      rd_mux = {2'b00, gain_reg}; // see RULE20
    end else if (addr_s == `HSC_OFF_MID) begin
      rd_mux = mid_reg;
    end else if (addr_s == `HSC_OFF_OUTER) begin
      rd_mux = outer_reg;
    end else if (addr_s == `HSC_OFF_SCALE) begin
      rd_mux = scale_reg;
    end else if (addr_s == `HSC_OFF_AFC) begin
      rd_mux = afc_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      soft_reg <= 1'b0;
      idle_reg <= 1'b1;
      tb_reg <= `HSC_RST_TB;
      intdis_reg <= 1'b0;
      intfn_reg <= 1'b0;
      gain_reg <= `HSC_RST_GAIN; // see RULE9
      scale_reg <= `HSC_RST_SCALE; // see RULE1
      afc_reg <= `HSC_RST_AFC;
      mid_reg <= `HSC_RST_MID;
      outer_reg <= `HSC_RST_OUTER;
    end else if (ce && wr) begin
      if (addr_s == `HSC_OFF_CTRL1) begin
        idle_reg <= wd_s[`HSC_C1_IDLE]; // see RULE17
        tb_reg <= wd_s[`HSC_C1_TB_HI:`HSC_C1_TB_LO];
        intdis_reg <= wd_s[`HSC_C1_INTDIS];
        intfn_reg <= wd_s[`HSC_C1_INTFN];
        soft_reg <= wd_s[`HSC_C1_SOFT];
      end else if (addr_s == `HSC_OFF_GAIN) begin
        gain_reg <= wd_s[5:0]; // see RULE9
      end else if (addr_s == `HSC_OFF_MID) begin
        mid_reg <= wd_s;
      end else if (addr_s == `HSC_OFF_OUTER) begin
        outer_reg <= wd_s;
      end else if (addr_s == `HSC_OFF_SCALE) begin
        scale_reg <= wd_s;
      end else if (addr_s == `HSC_OFF_AFC) begin
        afc_reg <= wd_s;
      end
    end
  end

  // ----------------------------------------
  // link answer, init delay, timebase
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
      busy_reg <= 1'b1;
      init_cnt <= 32'h0;
      tb_cnt <= 32'h0;
      factor_reg <= 16'h0000;
    end else if (ce) begin
      factor_reg <= scale_factor(scale_reg); // see RULE2
      if (acc) begin
        rdata_reg <= rd_mux;
        ack_reg <= 1'b1;
      end else if (!req_s) begin
        ack_reg <= 1'b0;
      end
      if (busy_reg) begin
        init_cnt <= init_cnt + 32'h1;
        busy_reg <= init_cnt != 32'(INIT_CYC - 1);
      end
      tb_cnt <= (tick || idle_reg) ? 32'h0 : tb_cnt + 32'h1;
    end
  end

  // ----------------------------------------
  // dual-spin conversion
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      cst_reg <= C_IDLE;
      elem_reg <= 3'h0;
      rev_reg <= 1'b0;
      adc_req_reg <= 1'b0;
      dv_reg <= 1'b0;
      int_low_reg <= 1'b1;
      pend_reg <= 1'b0;
    end else if (ce) begin
      adc_req_reg <= 1'b0;
      if (y_read) begin
        int_low_reg <= 1'b1;
      end
      case (cst_reg)
        C_IDLE: if (pend_reg) begin
          pend_reg <= 1'b0;
          dv_reg <= 1'b0;
          elem_reg <= 3'h0;
          rev_reg <= 1'b0;
          cst_reg <= C_SAMP;
        end
        C_SAMP: begin
          adc_req_reg <= 1'b1;
          cst_reg <= C_WAIT;
        end
        C_WAIT: if (adc_valid) begin
          // forward spin first, then reverse, element by element (see RULE7)
          rev_reg <= !rev_reg;
          if (rev_reg && elem_reg == `HSC_LAST_ELEM) begin
            cst_reg <= C_DONE;
          end else begin
            elem_reg <= rev_reg ? elem_reg + 3'h1 : elem_reg;
            cst_reg <= C_SAMP;
          end
        end
        default: begin
          dv_reg <= 1'b1;
          // threshold mode is not modelled, so it raises nothing
          if (!intdis_reg && !intfn_reg) begin
            int_low_reg <= 1'b0; // see RULE18
          end
          cst_reg <= C_IDLE;
        end
      endcase
      // a start arriving while one is being taken is kept
      if (start_ev) begin
        pend_reg <= 1'b1;
      end
    end
  end

  // snapshot copy keeps results stable while the next cycle samples (see RULE5)
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      for (int i = 0; i < 10; i++) begin
        res_reg[i] <= 12'h000;
      end
    end else if (ce && cst_reg == C_DONE) begin
      res_reg <= work_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && cst_reg == C_WAIT && adc_valid) begin
      work_reg[{elem_reg, rev_reg}] <= adc_data; // see RULE6
    end
  end

  assign link.rdata = rdata_reg;
  assign link.ack = ack_reg;
  assign link.int_drv_o = 1'b0;
  assign link.int_drv_oe = !int_low_reg;
  assign adc_req = adc_req_reg;
  assign adc_elem = elem_reg;
  assign adc_rev = rev_reg;
  assign gain_code = gain_reg;
  assign scale_x10 = factor_reg;
  assign polarity_inv = afc_reg[`HSC_AFC_INV_BIT];
  assign idle_mode = idle_reg;
endmodule
`default_nettype wire

// ### logic/hsc_host.sv
// host end: APB command registers, reset and init sequencer, link master
`timescale 1ns/1ns
`default_nettype none
`include "hsc_map.svh"
module hsc_host #(
  parameter int WAIT_CYC = `HSC_WAIT_CYC,
  parameter int LINK_DIV = `HSC_LINK_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  hsc_link_if.host link
);
  import hsc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  hsc_host_e st_reg;
  hsc_xfer_e xst_reg;
  logic [9:0] s1_reg, s2_reg;
  logic [31:0] cfg_reg, cnt_reg, prdata_reg, div_cnt;
  logic pready_reg, pslverr_reg, pol_reg, done_reg, job_reg, job_we_reg;
  logic go_reg, xdone_reg, req_reg, lclk_reg, pin_reg, xwe_reg;
  logic [7:0] job_a_reg, job_d_reg, xa_reg, xd_reg, rd_reg;
  logic [2:0] idx_reg;

  wire ack_s = s2_reg[9];
  wire int_s = s2_reg[8];
  wire [7:0] rdata_s = s2_reg[7:0];
  wire busy = st_reg != H_IDLE || job_reg;
  wire setup = psel && !penable;
  wire wr = psel && penable && pready_reg && pwrite;
  // test bits held at reset pattern, only polarity varies (see RULE3)
  wire [7:0] afc_val = `HSC_RST_AFC | {6'h00, pol_reg, 1'b0};
  wire [7:0] afc_flip = `HSC_RST_AFC | {6'h00, !pol_reg, 1'b0};
  wire ready_seen = rd_reg == `HSC_READY_A || rd_reg == `HSC_READY_B;
  wire mapped = paddr == `HSC_APB_CTRL || paddr == `HSC_APB_ACC ||
    paddr == `HSC_APB_STAT || paddr == `HSC_APB_CFG;
  wire [31:0] stat = {16'h0000, rd_reg, 5'h00, !int_s, done_reg, busy};
  wire [31:0] rd_sel = (paddr == `HSC_APB_STAT) ? stat :
    (paddr == `HSC_APB_CFG) ? cfg_reg : 32'h0;

  // init writes: polarity, middle, outer, scale, then mode last (see RULE15)
  function automatic logic [15:0] cfg_item(input logic [2:0] i, input logic [31:0] c,
      input logic [7:0] afc);
    logic [15:0] r;
    r = {`HSC_OFF_CTRL1, c[31:24]};
    if (i == 3'h0) begin
      r = {`HSC_OFF_AFC, afc}; // see RULE4
    end else if (i == 3'h1) begin
      r = {`HSC_OFF_MID, c[7:0]};
    end else if (i == 3'h2) begin
      r = {`HSC_OFF_OUTER, c[15:8]};
    end else if (i == 3'h3) begin
      r = {`HSC_OFF_SCALE, c[23:16]};
    end
    return r;
  endfunction
  wire [15:0] next_item = cfg_item(idx_reg + 3'h1, cfg_reg, afc_val);
  wire [15:0] first_item = cfg_item(3'h0, cfg_reg, afc_val);

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= 10'h100;
      s2_reg <= 10'h100;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      cfg_reg <= `HSC_RST_CFG;
    end else if (ce) begin
      s1_reg <= {link.ack, link.interrupt_out_low, link.rdata};
      s2_reg <= s1_reg;
      pready_reg <= setup;
      if (setup) begin
        prdata_reg <= rd_sel;
        pslverr_reg <= !mapped;
      end
      if (wr && paddr == `HSC_APB_CFG && !busy) begin
        cfg_reg <= pwdata;
      end
    end
  end

  // ----------------------------------------
  // link clock divider and transfer engine
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt <= 32'h0;
      lclk_reg <= 1'b0;
      xst_reg <= X_IDLE;
      req_reg <= 1'b0;
      xdone_reg <= 1'b0;
      rd_reg <= 8'h00;
    end else if (ce) begin
      div_cnt <= (div_cnt == 32'(LINK_DIV / 2 - 1)) ? 32'h0 : div_cnt + 32'h1;
      if (div_cnt == 32'(LINK_DIV / 2 - 1)) begin
        lclk_reg <= !lclk_reg;
      end
      xdone_reg <= 1'b0;
      case (xst_reg)
        X_IDLE: if (go_reg) begin
          req_reg <= 1'b1;
          xst_reg <= X_REQ;
        end
        X_REQ: if (ack_s) begin
          rd_reg <= rdata_s;
          req_reg <= 1'b0;
          xst_reg <= X_REL;
        end
        default: if (!ack_s) begin
          xdone_reg <= 1'b1;
          xst_reg <= X_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // reset and init sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= H_IDLE;
      cnt_reg <= 32'h0;
      pin_reg <= 1'b1;
      done_reg <= 1'b0;
      pol_reg <= 1'b0;
      job_reg <= 1'b0;
      job_we_reg <= 1'b0;
      job_a_reg <= 8'h00;
      job_d_reg <= 8'h00;
      go_reg <= 1'b0;
      xa_reg <= 8'h00;
      xd_reg <= 8'h00;
      xwe_reg <= 1'b0;
      idx_reg <= 3'h0;
    end else if (ce) begin
      go_reg <= 1'b0;
      if (wr && !busy && paddr == `HSC_APB_ACC) begin
        job_reg <= 1'b1;
        job_we_reg <= pwdata[16];
        job_a_reg <= pwdata[15:8];
        job_d_reg <= pwdata[7:0];
      end else if (wr && !busy && paddr == `HSC_APB_CTRL) begin
        pol_reg <= pwdata[2] ? !pol_reg : pwdata[1];
        if (pwdata[2]) begin
          job_reg <= 1'b1; // see RULE16
          job_we_reg <= 1'b1;
          job_a_reg <= `HSC_OFF_AFC;
          job_d_reg <= afc_flip;
        end else if (pwdata[0]) begin
          done_reg <= 1'b0;
          cnt_reg <= 32'h0;
          pin_reg <= 1'b0;
          st_reg <= H_RST;
        end
      end
      case (st_reg)
        H_IDLE: if (job_reg) begin
          job_reg <= 1'b0;
          xa_reg <= job_a_reg;
          xd_reg <= job_d_reg;
          xwe_reg <= job_we_reg;
          go_reg <= 1'b1;
          st_reg <= H_JOB;
        end
        H_RST: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(`HSC_RST_CYC - 1)) begin
            pin_reg <= 1'b1; // see RULE12
            cnt_reg <= 32'h0;
            st_reg <= H_WAIT;
          end
        end
        H_WAIT: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(WAIT_CYC - 1)) begin
            xa_reg <= `HSC_OFF_CTRL1; // see RULE13
            xwe_reg <= 1'b0;
            go_reg <= 1'b1;
            st_reg <= H_POLL;
          end
        end
        H_POLL: if (xdone_reg) begin
          go_reg <= 1'b1;
          if (ready_seen) begin
            idx_reg <= 3'h0;
            {xa_reg, xd_reg} <= first_item; // see RULE14
            xwe_reg <= 1'b1;
            st_reg <= H_CFG;
          end
        end
        H_CFG: if (xdone_reg) begin
          if (idx_reg == 3'h4) begin
            done_reg <= 1'b1;
            st_reg <= H_IDLE;
          end else begin
            idx_reg <= idx_reg + 3'h1;
            {xa_reg, xd_reg} <= next_item; // see RULE15
            go_reg <= 1'b1;
          end
        end
        default: if (xdone_reg) begin
          st_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign link.link_clk = lclk_reg;
  assign link.reset_pin_low = pin_reg;
  assign link.req = req_reg;
  assign link.we = xwe_reg;
  assign link.addr = xa_reg;
  assign link.wdata = xd_reg;
endmodule
`default_nettype wire

// ### pkg/hsc_link_if.sv
// link between host controller and sensor device
`timescale 1ns/1ns
`default_nettype none
interface hsc_link_if;
  logic link_clk;
  logic reset_pin_low;
  logic req;
  logic we;
  hsc_pkg::hsc_byte_t addr;
  hsc_pkg::hsc_byte_t wdata;
  hsc_pkg::hsc_byte_t rdata;
  logic ack;
  logic int_drv_o;
  logic int_drv_oe;
  wire interrupt_out_low;
  // open-drain line with pull-up
  assign interrupt_out_low = int_drv_oe ? int_drv_o : 1'b1;
  modport dev (input link_clk, reset_pin_low, req, we, addr, wdata,
    output rdata, ack, int_drv_o, int_drv_oe);
  modport host (output link_clk, reset_pin_low, req, we, addr, wdata,
    input rdata, ack, interrupt_out_low);
endinterface
`default_nettype wire

// ### pkg/hsc_map.svh
// register offsets, reset values and timing counts of the hall sensor link
`ifndef HSC_MAP_SVH
`define HSC_MAP_SVH
`define HSC_OFF_CTRL1 8'h0F
`define HSC_OFF_Y 8'h11
`define HSC_OFF_RAW_LO 8'h16
`define HSC_OFF_RAW_HI 8'h29
`define HSC_OFF_GAIN 8'h2A
`define HSC_OFF_MID 8'h2B
`define HSC_OFF_OUTER 8'h2C
`define HSC_OFF_SCALE 8'h2D
`define HSC_OFF_AFC 8'h2E
`define HSC_RST_GAIN 6'h20
`define HSC_RST_SCALE 8'h09
`define HSC_RST_AFC 8'h84
`define HSC_RST_MID 8'h00
`define HSC_RST_OUTER 8'h06
`define HSC_RST_TB 3'h7
`define HSC_READY_A 8'hF0
`define HSC_READY_B 8'hF1
`define HSC_AFC_INV_BIT 1
`define HSC_C1_IDLE 7
`define HSC_C1_TB_HI 6
`define HSC_C1_TB_LO 4
`define HSC_C1_INTDIS 3
`define HSC_C1_INTFN 2
`define HSC_C1_SOFT 1
`define HSC_LAST_ELEM 3'h4
`define HSC_CLK_NS 20
`define HSC_RST_PULSE_NS 100
`define HSC_RST_CYC (`HSC_RST_PULSE_NS / `HSC_CLK_NS + 1)
`define HSC_POLL_WAIT_US 1000
`define HSC_WAIT_CYC (`HSC_POLL_WAIT_US * 1000 / `HSC_CLK_NS)
`define HSC_INIT_CYC 1000
`define HSC_TB_UNIT 1000
`define HSC_LINK_DIV 8
`define HSC_APB_CTRL 8'h00
`define HSC_APB_ACC 8'h04
`define HSC_APB_STAT 8'h08
`define HSC_APB_CFG 8'h0C
`define HSC_RST_CFG 32'hF0090600
`endif

// ### pkg/hsc_pkg.sv
// types shared by both ends of the hall sensor link
package hsc_pkg;
  typedef logic [7:0] hsc_byte_t;
  typedef logic [11:0] hsc_sample_t;
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_SAMP = 2'b01, C_WAIT = 2'b11, C_DONE = 2'b10} hsc_conv_e;
  typedef enum logic [1:0] {X_IDLE = 2'b00, X_REQ = 2'b01, X_REL = 2'b11} hsc_xfer_e;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_RST = 3'b001, H_WAIT = 3'b011, H_POLL = 3'b010, H_CFG = 3'b110,
    H_JOB = 3'b111
  } hsc_host_e;
endpackage

// ### tb/hall_sensor_config_readout_test.sv
// bench: host and device joined by the link, apb driver and sample source
`timescale 1ns/1ns
`default_nettype none
`include "hsc_map.svh"
module hall_sensor_config_readout_test;
  import hsc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic adc_valid = 1'b0;
  logic pend = 1'b0;
  logic rv = 1'b0;
  logic err;
  logic [2:0] el = 3'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, adc_req, adc_rev, polarity_inv, idle_mode;
  logic [2:0] adc_elem;
  logic [5:0] gain_code;
  logic [15:0] scale_x10;
  logic [31:0] seed = 32'd98;
  hsc_sample_t adc_data = 12'h000;
  hsc_sample_t samp [5][2];
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] sc_code [6] = '{8'h1F, 8'h08, 8'h01, 8'h43, 8'h09, 8'h32};
  logic [15:0] sc_x10 [6] = '{16'h0139, 16'h0457, 16'h1388, 16'h1653, 16'h03E8, 16'h0000};
  hsc_link_if link ();
  hsc_host #(.WAIT_CYC(200), .LINK_DIV(8)) i_hsc_host (.clk(clk), .rst_n(rst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
  hsc_device #(.INIT_CYC(20), .TB_UNIT(50)) i_hsc_device (.clk(clk), .rst_n(rst_n), .ce(ce),
    .link(link.dev), .adc_req(adc_req), .adc_elem(adc_elem), .adc_rev(adc_rev),
    .adc_valid(adc_valid), .adc_data(adc_data), .gain_code(gain_code), .scale_x10(scale_x10),
    .polarity_inv(polarity_inv), .idle_mode(idle_mode));
  hsc_checker i_hsc_checker (.clk(clk), .rst_n(rst_n), .link_clk(link.link_clk),
    .reset_pin_low(link.reset_pin_low), .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .int_drv_o(link.int_drv_o),
    .int_drv_oe(link.int_drv_oe), .interrupt_out_low(link.interrupt_out_low));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  // groups of four from 16h: elements 3,2,1,0 then centre; reverse spin first
  function automatic logic [7:0] raw_exp(input int a);
    int e;
    int k;
    hsc_sample_t s;
    e = (a - 'h16) / 4;
    k = (a - 'h16) % 4;
    s = samp[(e == 4) ? 4 : 3 - e][k < 2];
    return (k % 2 == 0) ? {{4{s[11]}}, s[11:8]} : s[7:0];
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++t < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input int b, input logic v);
    int t;
    t = 0;
    do apb(1'b0, 8'h08, 32'h0); while (rd[b] !== v && ++t < 3000);
    cmp(rd[b], v, "status bit");
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, 8'h04, {15'h0000, w, a, d});
    poll(0, 1'b0);
  endtask
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // stimulus and checks
  // ----------------------------------------
  always #10 clk = ~clk;
  // the source stalls at random so the device must wait for each sample
  always @(posedge clk) begin
    seed <= xs(seed);
    adc_valid <= 1'b0;
    if (adc_req) begin
      pend <= 1'b1;
      el <= adc_elem;
      rv <= adc_rev;
    end else if (pend && seed[0]) begin
      pend <= 1'b0;
      adc_valid <= 1'b1;
      adc_data <= seed[23:12];
      samp[el][rv] <= seed[23:12];
    end
  end
  initial begin
    #(20 * 60000);
    n_errors++;
    close_out();
  end
  initial begin
    logic [5:0] g;
    logic [7:0] rb [20];
    int cv;
    int cx;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h0C, 32'h0);
    cmp(rd, `HSC_RST_CFG, "cfg reset");
    cmp(gain_code, 6'h20, "gain reset");
    cmp(scale_x10, 16'h03E8, "scale reset");
    apb(1'b0, 8'h10, 32'h0);
    cmp(err, 1'b1, "unmapped offset");
    apb(1'b1, 8'h00, 32'h3);
    poll(1, 1'b1);
    cmp({polarity_inv, idle_mode}, 2'b11, "polarity and idle");
    acc(1'b0, 8'h2E, 8'h00);
    cmp(rd[15:8], 8'h86, "front config inverted");
    apb(1'b1, 8'h00, 32'h4);
    poll(0, 1'b0);
    acc(1'b0, 8'h2E, 8'h00);
    cmp({polarity_inv, rd[15:8]}, 9'h084, "polarity toggled");
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, 8'h2D, sc_code[i]);
      cmp(scale_x10, sc_x10[i], "scale factor");
    end
    g = seed[5:0];
    acc(1'b1, 8'h2A, {2'b11, g});
    acc(1'b0, 8'h2A, 8'h00);
    cmp({rd[15:8], gain_code}, {2'b00, g, g}, "gain field");
    acc(1'b1, 8'h2A, 8'h3F);
    cmp(gain_code, 6'h3F, "max gain");
    for (int n = 0; n < 2; n++) begin
      poll(2, 1'b1);
      for (int a = 'h16; a < 'h2A; a++) begin
        acc(1'b0, a[7:0], 8'h00);
        cmp(rd[15:8], raw_exp(a), "raw element byte");
        rb[a - 'h16] = rd[15:8];
      end
      cv = ($signed({rb[18][3:0], rb[19]}) - $signed({rb[16][3:0], rb[17]})) / 2;
      cx = ($signed(samp[4][0]) - $signed(samp[4][1])) / 2;
      cmp(cv, cx, "centre reading");
      acc(1'b0, 8'h11, 8'h00);
    end
    acc(1'b1, 8'h0F, 8'h00);
    cmp(idle_mode, 1'b0, "low power mode");
    poll(2, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire

// ### tb/hsc_checker.sv
// concurrent checks on the signals between host and device
`timescale 1ns/1ns
`default_nettype none
module hsc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic reset_pin_low,
  input wire logic req,
  input wire logic we,
  input wire hsc_pkg::hsc_byte_t addr,
  input wire hsc_pkg::hsc_byte_t wdata,
  input wire hsc_pkg::hsc_byte_t rdata,
  input wire logic ack,
  input wire logic int_drv_o,
  input wire logic int_drv_oe,
  input wire logic interrupt_out_low
);
  // ----------------------------------------
  // link handshake, reset pulse, interrupt
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_REQ_HOLD: assert property (req && !ack |=> req)
    else $error("request dropped before answer");
  AST_REQ_FIELDS: assert property (req && $past(req) |-> $stable({we, addr, wdata}))
    else $error("request fields moved while pending");
  AST_ACK_BOUND: assert property ($rose(req) |-> ##[2:24] ack)
    else $error("no answer in time");
  AST_ACK_CAUSE: assert property ($rose(ack) |-> req)
    else $error("answer without request");
  AST_ACK_STAND: assert property (ack && req |=> ack && $stable(rdata))
    else $error("answer not held");
  AST_ACK_DROP: assert property ($fell(req) |-> ##[1:6] !ack)
    else $error("answer not withdrawn");
  AST_NEXT_WAIT: assert property (!req && ack |=> !req)
    else $error("new request before answer fell");
  AST_RST_PULSE: assert property ($fell(reset_pin_low) |-> !reset_pin_low[*6] ##1 reset_pin_low)
    else $error("reset pulse width wrong");
  AST_LINK_DIV: assert property ($rose(link_clk) |-> link_clk[*4] ##1 !link_clk[*4])
    else $error("link clock period wrong");
  AST_INT_LEVEL: assert property (int_drv_oe |-> !int_drv_o && !interrupt_out_low)
    else $error("interrupt line not pulled low");
endmodule
`default_nettype wire
